// [frod_consts.svh]
// Overview of operation
// RULE_01: destination bit 0 writes working_accumulator, 1 writes the addressed register.
// RULE_02: bank bit 0 uses access bank, 1 uses data_page_pointer for the bank.
// RULE_03: byte and bit operations carry an 8-bit register address in the low byte.
// RULE_04: reg_to_reg_move is two words, 1100 source then 1111 destination, two cycles, no flags.
// RULE_05: bit operations use a 3-bit field picking the bit of the register.
// RULE_06: literal format carries an 8-bit immediate in the low byte.
// RULE_07: absolute_jump and call carry a 20-bit target, low byte first, 1111 second word.
// RULE_08: relative_jump has 11-bit signed offset; conditional branches an 8-bit signed offset.
// RULE_09: call carries one fast-mode bit in its first word.
// RULE_10: fast bit 1 moves context via shadow registers; 0 leaves shadows untouched.
// RULE_11: add_acc_to_reg 0010 01da, add_acc_reg_carry 0010 00da; both update all five flags.
// RULE_12: prefix 0001 is or, and, xor, complement; these update only zero and negative.
// RULE_13: compare skips use 0110 with 001a, 010a, 000a; no flags change.
// RULE_14: skip or test takes one cycle, plus a no-operation cycle when taken.
// RULE_15: a lone second word starting 1111 executes as no-operation.
// RULE_16: read-modify-write of a port register sources the pin levels, not the latch.
// RULE_17: writing timer_zero_count back to register clears its prescaler when assigned.
// RULE_18: inc and dec skip forms 0011 11da, 0010 11da, 0100 10da, 0100 11da; no flags.
// RULE_19: rotates through carry update carry, zero, negative; plain rotates update zero, negative.
// RULE_20: prefix 0101 subtracts 11da, 10da, 01da update all five arithmetic flags.
// RULE_21: multiply_acc_reg 0000 001a is single cycle, 16-bit product, no flags.
// RULE_22: bit_toggle prefix 0111, bit_test_skip_set prefix 1010; bit operations change no flags.
// RULE_23: bit clear, set and test-clear prefixes come from parameters, not guesses.
// RULE_24: bit clear, set, toggle alter only the selected bit of the register.
`ifndef FROD_CONSTS_SVH
`define FROD_CONSTS_SVH
// register byte offsets
`define FROD_CTRL_OFS 8'h00
`define FROD_PAGE_OFS 8'h04
`define FROD_TMR_OFS 8'h08
`define FROD_PLO_OFS 8'h0C
`define FROD_PHI_OFS 8'h10
`define FROD_STAT_OFS 8'h14
// control fields and reset values
`define FROD_CTRL_EN 0
`define FROD_CTRL_PSA 1
`define FROD_CTRL_RST 2'h1
`define FROD_PAGE_RST 4'h0
`define FROD_TMR_RST 12'h000
`define FROD_PLO_RST 12'hFFF
`define FROD_PHI_RST 12'h000
// status fields
`define FROD_STAT_PEND 8
`define FROD_STAT_CNT 16
// flag mask, bits C DC Z OV N from 0 upward
`define FROD_FL_ALL 5'h1F
`define FROD_FL_ZN 5'h14
`define FROD_FL_CZN 5'h15
`define FROD_FL_Z 5'h04
`define FROD_FL_NONE 5'h00
// prefixes
`define FROD_PFX_EXT 4'hF
`define FROD_PFX_MOVE 4'hC
`define FROD_PFX_TOG 4'h7
`define FROD_PFX_TSS 4'hA
`define FROD_PFX_REL 4'hD
`define FROD_PFX_CTL 4'hE
`define FROD_CALL_SEL 3'h6
`define FROD_JUMP_SEL 4'hF
`endif

// [frod_pkg.sv]
package frod_pkg;
  typedef enum logic [5:0] {
    OP_OTHER = 6'h00, OP_NOP = 6'h01, OP_ILLEGAL = 6'h02, OP_MUL = 6'h03,
    OP_DEC = 6'h04, OP_OR = 6'h05, OP_AND = 6'h06, OP_XOR = 6'h07,
    OP_COM = 6'h08, OP_ADDC = 6'h09, OP_ADD = 6'h0A, OP_INC = 6'h0B,
    OP_DECSZ = 6'h0C, OP_RRC = 6'h0D, OP_RLC = 6'h0E, OP_SWAP = 6'h0F,
    OP_INCSZ = 6'h10, OP_RRN = 6'h11, OP_RLN = 6'h12, OP_INCSNZ = 6'h13,
    OP_DECSNZ = 6'h14, OP_MOVF = 6'h15, OP_SUBRB = 6'h16, OP_SUBAB = 6'h17,
    OP_SUBA = 6'h18, OP_CPSLT = 6'h19, OP_CPSEQ = 6'h1A, OP_CPSGT = 6'h1B,
    OP_TSTSZ = 6'h1C, OP_SETF = 6'h1D, OP_CLRF = 6'h1E, OP_NEG = 6'h1F,
    OP_MOVWF = 6'h20, OP_BTOG = 6'h21, OP_BTSS = 6'h22, OP_BCLR = 6'h23,
    OP_BSET = 6'h24, OP_BTSC = 6'h25, OP_MOVE = 6'h26, OP_REL = 6'h27,
    OP_BCOND = 6'h28, OP_CALL = 6'h29, OP_JUMP = 6'h2A
  } frod_op_t;
  typedef enum logic {
    ST_ONE = 1'b0,
    ST_TWO = 1'b1
  } frod_st_t;
endpackage : frod_pkg

// [frod_decoder.sv]
`timescale 1ns/100ps
`include "frod_consts.svh"
module frod_decoder #(
  parameter logic [3:0] BIT_CLR_PFX = 4'h0,
  parameter logic [3:0] BIT_SET_PFX = 4'h0,
  parameter logic [3:0] BIT_TSC_PFX = 4'h0,
  parameter logic BIT_PFX_KNOWN = 1'b0,
  parameter logic [7:0] ACC_SPLIT = 8'h80,
  parameter logic [3:0] ACC_LO_PAGE = 4'h0,
  parameter logic [3:0] ACC_HI_PAGE = 4'hF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [15:0] instr_word,
  output logic dec_valid,
  output frod_pkg::frod_op_t dec_op,
  output logic dec_dest_reg,
  output logic dec_dest_acc,
  output logic dec_bank_ptr,
  output logic [11:0] dec_addr,
  output logic [11:0] dec_src_addr,
  output logic [11:0] dec_dst_addr,
  output logic [2:0] dec_bit,
  output logic [7:0] dec_bit_mask,
  output logic [7:0] dec_literal,
  output logic [19:0] dec_target,
  output logic [10:0] dec_offset,
  output logic dec_fast,
  output logic [4:0] dec_flags,
  output logic dec_two_cycle,
  output logic dec_skip_cond,
  output logic dec_pin_source,
  output logic dec_prescale_clr
);
  import frod_pkg::*;

  // ********************************
  // register file
  // ********************************
  logic [1:0] ctrl;
  logic [3:0] data_page_pointer;
  logic [11:0] tmr_addr;
  logic [11:0] port_lo;
  logic [11:0] port_hi;
  logic [15:0] dec_count;
  frod_op_t last_op;
  frod_st_t st;
  logic [15:0] pend;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic bus_go;

  assign bus_go = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= bus_go & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `FROD_CTRL_RST;
      data_page_pointer <= `FROD_PAGE_RST;
      tmr_addr <= `FROD_TMR_RST;
      port_lo <= `FROD_PLO_RST;
      port_hi <= `FROD_PHI_RST;
    end else if (wr_pend) begin
      case (wr_addr)
        `FROD_CTRL_OFS: ctrl <= hwdata[1:0];
        `FROD_PAGE_OFS: data_page_pointer <= hwdata[3:0];
        `FROD_TMR_OFS: tmr_addr <= hwdata[11:0];
        `FROD_PLO_OFS: port_lo <= hwdata[11:0];
        `FROD_PHI_OFS: port_hi <= hwdata[11:0];
        default: ;
      endcase
    end
  end

  // read data sampled in the address phase; unmapped reads as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_go & !hwrite) begin
      hrdata <= 32'h0000_0000;
      case (haddr[7:0])
        `FROD_CTRL_OFS: hrdata[1:0] <= ctrl;
        `FROD_PAGE_OFS: hrdata[3:0] <= data_page_pointer;
        `FROD_TMR_OFS: hrdata[11:0] <= tmr_addr;
        `FROD_PLO_OFS: hrdata[11:0] <= port_lo;
        `FROD_PHI_OFS: hrdata[11:0] <= port_hi;
        `FROD_STAT_OFS: begin
          hrdata[5:0] <= last_op;
          hrdata[`FROD_STAT_PEND] <= (st == ST_TWO);
          hrdata[`FROD_STAT_CNT +: 16] <= dec_count;
        end
        default: ;
      endcase
    end
  end

  // ********************************
  // word decode
  // ********************************
  logic [15:0] w;
  logic take;
  logic second_ok;
  frod_op_t op;
  logic has_d;
  logic fixed_reg;
  logic reads_f;
  logic file_op;
  logic [4:0] flags;
  logic [11:0] eff;
  logic dest_reg;

  assign instr_ready = ctrl[`FROD_CTRL_EN];
  assign take = instr_valid & instr_ready;
  // while a pair is open the first word drives the decode
  assign w = (st == ST_TWO) ? pend : instr_word;
  assign second_ok = (instr_word[15:12] == `FROD_PFX_EXT);

  always_comb begin
    op = OP_OTHER;
    case (w[15:12])
      4'h0: begin
        if (w[11:9] == 3'h1) op = OP_MUL; // RULE_21
        else if (w[11:10] == 2'h1) op = OP_DEC;
        else if (w == 16'h0000) op = OP_NOP;
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        case ({w[15:12], w[11:10]})
          6'h04: op = OP_OR; // RULE_12
          6'h05: op = OP_AND;
          6'h06: op = OP_XOR;
          6'h07: op = OP_COM;
          6'h08: op = OP_ADDC; // RULE_11
          6'h09: op = OP_ADD;
          6'h0A: op = OP_INC;
          6'h0B: op = OP_DECSZ; // RULE_18
          6'h0C: op = OP_RRC; // RULE_19
          6'h0D: op = OP_RLC;
          6'h0E: op = OP_SWAP;
          6'h0F: op = OP_INCSZ;
          6'h10: op = OP_RRN;
          6'h11: op = OP_RLN;
          6'h12: op = OP_INCSNZ;
          6'h13: op = OP_DECSNZ;
          6'h14: op = OP_MOVF;
          6'h15: op = OP_SUBRB; // RULE_20
          6'h16: op = OP_SUBAB;
          6'h17: op = OP_SUBA;
          default: op = OP_OTHER;
        endcase
      end
      4'h6: begin
        case (w[11:9])
          3'h0: op = OP_CPSLT; // RULE_13
          3'h1: op = OP_CPSEQ;
          3'h2: op = OP_CPSGT;
          3'h3: op = OP_TSTSZ;
          3'h4: op = OP_SETF;
          3'h5: op = OP_CLRF;
          3'h6: op = OP_NEG;
          default: op = OP_MOVWF;
        endcase
      end
      `FROD_PFX_TOG: op = OP_BTOG; // RULE_22
      `FROD_PFX_TSS: op = OP_BTSS;
      `FROD_PFX_MOVE: op = OP_MOVE; // RULE_04
      `FROD_PFX_REL: op = w[11] ? OP_OTHER : OP_REL; // RULE_08
      `FROD_PFX_CTL: begin
        if (!w[11]) op = OP_BCOND;
        else if (w[11:9] == `FROD_CALL_SEL) op = OP_CALL;
        else if (w[11:8] == `FROD_JUMP_SEL) op = OP_JUMP;
      end
      `FROD_PFX_EXT: op = OP_NOP; // RULE_15
      default: op = OP_OTHER;
    endcase
    // unknown prefixes decode only once configured
    if (BIT_PFX_KNOWN && op == OP_OTHER) begin
      if (w[15:12] == BIT_CLR_PFX) op = OP_BCLR; // RULE_23
      else if (w[15:12] == BIT_SET_PFX) op = OP_BSET;
      else if (w[15:12] == BIT_TSC_PFX) op = OP_BTSC;
    end
    if (st == ST_TWO && !second_ok) op = OP_ILLEGAL;
  end

  always_comb begin
    flags = `FROD_FL_NONE;
    case (op)
      OP_ADD, OP_ADDC, OP_DEC, OP_INC, OP_NEG,
      OP_SUBA, OP_SUBAB, OP_SUBRB: flags = `FROD_FL_ALL; // RULE_11 RULE_20
      OP_OR, OP_AND, OP_XOR, OP_COM,
      OP_MOVF, OP_RLN, OP_RRN: flags = `FROD_FL_ZN; // RULE_12 RULE_19
      OP_RLC, OP_RRC: flags = `FROD_FL_CZN; // RULE_19
      OP_CLRF: flags = `FROD_FL_Z;
      default: flags = `FROD_FL_NONE; // RULE_13 RULE_18 RULE_21 RULE_22
    endcase
  end

  assign has_d = ((w[15:12] >= 4'h1) && (w[15:12] <= 4'h5)) || (op == OP_DEC);
  assign fixed_reg = (op inside {OP_SETF, OP_CLRF, OP_NEG, OP_MOVWF,
                                 OP_BCLR, OP_BSET, OP_BTOG}); // RULE_24
  assign file_op = !(op inside {OP_OTHER, OP_NOP, OP_ILLEGAL, OP_MOVE,
                                OP_REL, OP_BCOND, OP_CALL, OP_JUMP});
  assign reads_f = file_op && !(op inside {OP_SETF, OP_CLRF, OP_MOVWF});
  assign dest_reg = has_d ? w[9] : fixed_reg; // RULE_01

  // access bank splits low half to one page and high half to another
  always_comb begin
    if (w[8]) eff = {data_page_pointer, w[7:0]}; // RULE_02
    else if (w[7:0] < ACC_SPLIT) eff = {ACC_LO_PAGE, w[7:0]};
    else eff = {ACC_HI_PAGE, w[7:0]};
  end

  // ********************************
  // sequencing and output stage
  // ********************************
  logic pair_first;
  logic emit;

  assign pair_first = (st == ST_ONE) &&
                      (op == OP_MOVE || op == OP_CALL || op == OP_JUMP); // RULE_04 RULE_07
  assign emit = take && !pair_first;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= ST_ONE;
      pend <= 16'h0000;
    end else if (take) begin
      case (st)
        ST_ONE: begin
          if (pair_first) begin
            st <= ST_TWO;
            pend <= instr_word;
          end
        end
        ST_TWO: st <= ST_ONE;
        default: st <= ST_ONE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= emit;
    end
  end

  // ********************************
  // per-op classes
  // ********************************
  logic bit_op;
  logic skip_op;
  logic fixed_two;
  logic [7:0] bit_sel;

  assign bit_op = (op inside {OP_BCLR, OP_BSET, OP_BTOG, OP_BTSS, OP_BTSC});
  // the core adds the no-operation cycle; only the condition is flagged here
  assign skip_op = (op inside {OP_CPSLT, OP_CPSEQ, OP_CPSGT, OP_TSTSZ, OP_INCSZ,
                               OP_DECSZ, OP_INCSNZ, OP_DECSNZ, OP_BTSS, OP_BTSC,
                               OP_BCOND}); // RULE_14
  assign fixed_two = (op inside {OP_MOVE, OP_CALL, OP_JUMP, OP_REL}); // RULE_04 RULE_14

  // one lane per bit, so the mask needs no shifter
  for (genvar gi = 0; gi < 8; gi++) begin : g_bit_sel
    assign bit_sel[gi] = bit_op && (w[11:9] == 3'(gi)); // RULE_24
  end

  // ********************************
  // decoded outputs, one block per concern
  // ********************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_op <= OP_NOP;
      dec_flags <= `FROD_FL_NONE;
      dec_skip_cond <= 1'b0;
      dec_two_cycle <= 1'b0;
    end else if (emit) begin
      dec_op <= op;
      dec_flags <= flags;
      dec_skip_cond <= skip_op; // RULE_14
      dec_two_cycle <= fixed_two; // RULE_04 RULE_14
    end
  end

  // destination and effective address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_dest_reg <= 1'b0;
      dec_dest_acc <= 1'b0;
      dec_bank_ptr <= 1'b0;
      dec_addr <= 12'h000;
    end else if (emit) begin
      dec_dest_reg <= file_op && dest_reg; // RULE_01
      dec_dest_acc <= has_d && !w[9]; // RULE_01
      dec_bank_ptr <= file_op && w[8]; // RULE_02
      dec_addr <= eff; // RULE_03
    end
  end

  // operand fields, passed through whatever the op; the offset is the sign-extended low byte unless relative_jump; the bit mask stays zero unless a bit op
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_bit <= 3'h0;
      dec_bit_mask <= 8'h00;
      dec_literal <= 8'h00;
      dec_offset <= 11'h000;
    end else if (emit) begin
      dec_bit <= w[11:9]; // RULE_05
      dec_bit_mask <= bit_sel; // RULE_24
      dec_literal <= w[7:0]; // RULE_06
      dec_offset <= (op == OP_REL) ? w[10:0] : {{3{w[7]}}, w[7:0]}; // RULE_08
    end
  end

  // side effects on ports and the timer; both windows are set by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_pin_source <= 1'b0;
      dec_prescale_clr <= 1'b0;
    end else if (emit) begin
      dec_pin_source <= file_op && reads_f && dest_reg &&
                        (eff >= port_lo) && (eff <= port_hi); // RULE_16
      dec_prescale_clr <= file_op && dest_reg && (eff == tmr_addr) &&
                          ctrl[`FROD_CTRL_PSA]; // RULE_17
    end
  end

  // pair fields: first word in pend, second word on the bus now
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_src_addr <= 12'h000;
      dec_dst_addr <= 12'h000;
      dec_target <= 20'h00000;
      dec_fast <= 1'b0;
    end else if (emit) begin
      dec_src_addr <= (st == ST_TWO) ? pend[11:0] : 12'h000; // RULE_04
      dec_dst_addr <= (st == ST_TWO) ? instr_word[11:0] : 12'h000;
      dec_target <= (st == ST_TWO) ? {instr_word[11:0], pend[7:0]} : 20'h00000; // RULE_07
      dec_fast <= (op == OP_CALL) && w[8]; // RULE_09 RULE_10
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_count <= 16'h0000;
      last_op <= OP_NOP;
    end else if (emit) begin
      dec_count <= dec_count + 16'h0001;
      last_op <= op;
    end
  end
endmodule : frod_decoder

// [frod_props.sv]
`timescale 1ns/100ps
module frod_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] instr_word,
  input wire logic dec_valid,
  input wire frod_pkg::frod_op_t dec_op,
  input wire logic dec_dest_reg,
  input wire logic dec_dest_acc,
  input wire logic [2:0] dec_bit,
  input wire logic [7:0] dec_bit_mask,
  input wire logic [7:0] dec_literal,
  input wire logic [10:0] dec_offset,
  input wire logic [4:0] dec_flags,
  input wire logic dec_two_cycle,
  input wire logic dec_skip_cond
);
  import frod_pkg::*;
  // ****************
  // decode checks
  // ****************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_add_flags;
    dec_valid && dec_op inside {OP_ADD, OP_ADDC} |-> dec_flags == 5'h1F;
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flag mask wrong");
  property p_logic_flags;
    dec_valid && dec_op inside {OP_OR, OP_AND, OP_XOR, OP_COM} |-> dec_flags == 5'h14;
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logic flag mask wrong");
  property p_cmp_skip;
    dec_valid && dec_op inside {OP_CPSLT, OP_CPSEQ, OP_CPSGT} |-> !dec_flags && dec_skip_cond;
  endproperty
  a_cmp_skip: assert property (p_cmp_skip) else $error("compare decode wrong");
  property p_count_skip;
    dec_valid && dec_op inside {OP_INCSZ, OP_DECSZ, OP_INCSNZ, OP_DECSNZ}
      |-> !dec_flags && dec_skip_cond;
  endproperty
  a_count_skip: assert property (p_count_skip) else $error("count skip wrong");
  property p_move_pair;
    dec_valid && dec_op == OP_MOVE |-> dec_two_cycle && dec_flags == 5'h00;
  endproperty
  a_move_pair: assert property (p_move_pair) else $error("move decode wrong");
  property p_bit_mask;
    dec_valid && dec_op inside {OP_BTOG, OP_BTSS} |-> dec_bit_mask == (8'h01 << dec_bit);
  endproperty
  a_bit_mask: assert property (p_bit_mask) else $error("bit mask wrong");
  property p_low_byte;
    dec_valid && !dec_two_cycle && dec_op != OP_ILLEGAL |-> dec_literal == $past(instr_word[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte wrong");
  property p_dest_bit;
    dec_valid && dec_op == OP_ADD
      |-> dec_dest_reg == $past(instr_word[9]) && dec_dest_acc != $past(instr_word[9]);
  endproperty
  a_dest_bit: assert property (p_dest_bit) else $error("destination wrong");
  property p_rel_offset;
    dec_valid && dec_op == OP_REL |-> dec_offset == $past(instr_word[10:0]);
  endproperty
  a_rel_offset: assert property (p_rel_offset) else $error("offset wrong");
endmodule : frod_props

// [frod_fetch_model.sv]
`timescale 1ns/100ps
module frod_fetch_model (
  input wire logic hclk,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [15:0] instr_word
);
  // ****************
  // fetch side
  // ****************
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h0000;
  end
  // word held until taken; caller releases with idle so valid is never set twice a step
  task automatic send(input logic [15:0] w, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    instr_valid <= 1'b1;
    instr_word <= w;
    while (n < 50 && !ok) begin
      @(posedge hclk);
      ok = instr_ready;
      n++;
    end
  endtask : send
  // stale word is inverted so nothing decodes by accident
  task automatic idle;
    instr_valid <= 1'b0;
    instr_word <= ~instr_word;
  endtask : idle
endmodule : frod_fetch_model

// [tb.sv]
`timescale 1ns/100ps
module tb;
  import frod_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hreadyout, hresp, instr_valid, instr_ready, dec_valid, dec_dest_reg, dec_dest_acc;
  logic dec_bank_ptr, dec_fast, dec_two_cycle, dec_skip_cond, dec_pin_source, dec_prescale_clr;
  logic [15:0] instr_word;
  frod_op_t dec_op;
  logic [11:0] dec_addr, dec_src_addr, dec_dst_addr;
  logic [2:0] dec_bit;
  logic [7:0] dec_bit_mask, dec_literal;
  logic [19:0] dec_target;
  logic [10:0] dec_offset;
  logic [4:0] dec_flags;
  int failures = 0;
  int cmp_count = 0;
  // word, op, skip bit 7, flags bits 4:0
  logic [31:0] tbl [21] = '{32'h2633_0A1F, 32'h2233_091F, 32'h1233_0514, 32'h1633_0614,
    32'h1A33_0714, 32'h1E33_0814, 32'h6233_1A80, 32'h6433_1B80, 32'h6033_1980,
    32'h3E33_1080, 32'h2E33_0C80, 32'h4A33_1380, 32'h4E33_1480, 32'h3633_0E15,
    32'h3233_0D15, 32'h4633_1214, 32'h4233_1114, 32'h5E33_181F, 32'h5A33_171F,
    32'h5633_161F, 32'h0233_0300};
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  frod_decoder dut (.*);
  frod_fetch_model fetch (.*);
  // ****************
  // helpers
  // ****************
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic timeout;
    failures++;
    report_and_stop();
  endtask : timeout
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      if (++n > 20) timeout();
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : ahb
  task automatic put(input logic [15:0] w);
    logic ok;
    fetch.send(w, ok);
    if (!ok) timeout();
  endtask : put
  task automatic pair(input logic [15:0] a, input logic [15:0] b);
    int n;
    n = 0;
    // start on an edge so every input change lands right after one
    @(posedge hclk);
    put(a);
    if (b != 16'h0) put(b);
    fetch.idle();
    // the pulse stands only in the cycle after the last word is taken
    #1;
    while (dec_valid !== 1'b1 && n < 20) begin
      @(posedge hclk);
      #1;
      n++;
    end
    if (dec_valid !== 1'b1) timeout();
  endtask : pair
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    ahb(1'b0, 8'h0C, 0);
    cmp(rd, 32'hFFF);
    cmp({hreadyout, hresp}, 2'b10);
    ahb(1'b1, 8'h18, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h18, 0);
    cmp(rd, 32'h0);
    ahb(1'b1, 8'h00, 0);
    @(posedge hclk);
    #1;
    cmp(instr_ready, 1'b0);
    ahb(1'b1, 8'h00, 1);
    $display("register test done");
  endtask : t_regs
  task automatic t_table;
    for (int i = 0; i < 21; i++) begin
      pair(tbl[i][31:16], 16'h0);
      cmp(dec_op, tbl[i][15:8]);
      cmp(dec_flags, tbl[i][4:0]);
      cmp(dec_skip_cond, tbl[i][7]);
      cmp(dec_addr, 12'h033);
    end
    $display("opcode table test done");
  endtask : t_table
  task automatic t_bank_bits;
    ahb(1'b1, 8'h04, 5);
    pair(16'h2790, 16'h0);
    cmp({dec_addr, dec_bank_ptr, dec_dest_reg}, {12'h590, 2'b11});
    pair(16'h2490, 16'h0);
    cmp({dec_addr, dec_bank_ptr, dec_dest_acc}, {12'hF90, 2'b01});
    pair(16'h7A55, 16'h0);
    cmp({dec_op, dec_bit, dec_bit_mask}, {OP_BTOG, 3'h5, 8'h20});
    cmp(dec_literal, 8'h55);
    cmp(dec_flags, 5'h00);
    pair(16'hA7C4, 16'h0);
    cmp({dec_op, dec_addr, dec_skip_cond}, {OP_BTSS, 12'h5C4, 1'b1});
    $display("bank and bit test done");
  endtask : t_bank_bits
  task automatic t_pairs;
    pair(16'hC123, 16'hF456);
    cmp({dec_op, dec_src_addr, dec_dst_addr}, {OP_MOVE, 24'h123456});
    pair(16'hED12, 16'hF345);
    cmp({dec_op, dec_target, dec_fast}, {OP_CALL, 20'h34512, 1'b1});
    pair(16'hEC12, 16'hF345);
    cmp(dec_fast, 1'b0);
    pair(16'hEF34, 16'hF678);
    cmp({dec_op, dec_target, dec_two_cycle}, {OP_JUMP, 20'h67834, 1'b1});
    pair(16'hC123, 16'h2633);
    cmp(dec_op, OP_ILLEGAL);
    pair(16'hFABC, 16'h0);
    cmp(dec_op, OP_NOP);
    pair(16'hD7FF, 16'h0);
    cmp({dec_op, dec_offset}, {OP_REL, 11'h7FF});
    pair(16'hE0F0, 16'h0);
    cmp({dec_op, dec_offset, dec_skip_cond}, {OP_BCOND, 11'h7F0, 1'b1});
    ahb(1'b0, 8'h14, 0);
    cmp(rd, {16'h0021, 10'h000, OP_BCOND});
    $display("pair and branch test done");
  endtask : t_pairs
  task automatic t_side;
    ahb(1'b1, 8'h08, 32'h050);
    ahb(1'b1, 8'h00, 3);
    pair(16'h2650, 16'h0);
    cmp(dec_prescale_clr, 1'b1);
    pair(16'h2450, 16'h0);
    cmp(dec_prescale_clr, 1'b0);
    ahb(1'b1, 8'h00, 1);
    pair(16'h2650, 16'h0);
    cmp(dec_prescale_clr, 1'b0);
    ahb(1'b1, 8'h0C, 32'hF80);
    ahb(1'b1, 8'h10, 32'hF8F);
    pair(16'h2685, 16'h0);
    cmp(dec_pin_source, 1'b1);
    pair(16'h2485, 16'h0);
    cmp(dec_pin_source, 1'b0);
    $display("side effect test done");
  endtask : t_side
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_table();
    t_bank_bits();
    t_pairs();
    t_side();
    report_and_stop();
  end
endmodule : tb
bind frod_decoder frod_props u_props (.*);
